//--- fsw_pkg.sv
// shared constants and types for the flash status and write latch block
// assumes a 10 MHz core clock and a serial link clock from the host
package fsw_pkg;

  localparam int unsigned CLK_NS = 100;

  // opcodes seen on the serial link
  localparam logic [7:0] OP_SET_LATCH    = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH    = 8'h04;
  localparam logic [7:0] OP_VOL_ARM      = 8'h50;
  localparam logic [7:0] OP_RD_LOW       = 8'h05;
  localparam logic [7:0] OP_RD_HIGH      = 8'h35;
  localparam logic [7:0] OP_SR_WRITE     = 8'h01;
  localparam logic [7:0] OP_SR_WRITE_HI  = 8'h31;
  localparam logic [7:0] OP_PAGE_PROG    = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG    = 8'h32;
  localparam logic [7:0] OP_PAGE_ERASE   = 8'h81;
  localparam logic [7:0] OP_SECT_ERASE   = 8'h20;
  localparam logic [7:0] OP_HALF_ERASE   = 8'h52;
  localparam logic [7:0] OP_BLK_ERASE    = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] OP_BUF_PROG     = 8'h9D;
  localparam logic [7:0] OP_SECURE_ERASE = 8'h44;
  localparam logic [7:0] OP_SECURE_PROG  = 8'h42;
  localparam logic [7:0] OP_SUSPEND      = 8'h75;
  localparam logic [7:0] OP_RESUME       = 8'h7A;
  localparam logic [7:0] OP_QUAD_ON      = 8'h38;
  localparam logic [7:0] OP_QUAD_OFF     = 8'hFF;
  localparam logic [7:0] OP_RST_ENABLE   = 8'h66;
  localparam logic [7:0] OP_RST          = 8'h99;

  // link bit counts at frame end
  localparam logic [7:0] N_OPC  = 8'h08;
  localparam logic [7:0] N_ONE  = 8'h10;
  localparam logic [7:0] N_TWO  = 8'h18;
  localparam logic [7:0] N_ADDR = 8'h20;
  localparam logic [7:0] N_DATA = 8'h28;

  // status protect pair encodings
  localparam logic [1:0] SP_SOFT = 2'h0;
  localparam logic [1:0] SP_HW   = 2'h1;
  localparam logic [1:0] SP_PSU  = 2'h2;
  localparam logic [1:0] SP_OTP  = 2'h3;

  // security register address fields
  localparam logic [7:0] SEC_TOP  = 8'h00;
  localparam logic [2:0] SEC_GAP  = 3'h0;
  localparam logic [3:0] SEC_REG1 = 4'h1;
  localparam logic [3:0] SEC_REG3 = 4'h3;

  // status word, bit 15 down to bit 0
  typedef struct packed {
    logic       suspended;
    logic       protect_invert;
    logic [2:0] sec_lock;
    logic       op_fail;
    logic       quad_en;
    logic [1:0] status_protect;
    logic [4:0] block_protect;
    logic       write_latch;
    logic       busy;
  } fsw_stat_type;

  localparam fsw_stat_type STAT_RST   = '0;
  localparam fsw_stat_type NV_DEFAULT = '0;

  // request handed to the array engine
  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [1:0]  sec_sel;
  } fsw_arr_req_type;

  localparam fsw_arr_req_type REQ_RST = '0;

  typedef enum logic [3:0] {
    ST_LOAD = 4'h1,
    ST_IDLE = 4'h2,
    ST_SRW  = 4'h4,
    ST_ARR  = 4'h8
  } fsw_state_type;

endpackage

//--- fsw_sync.sv
// two flip-flop synchroniser for levels and toggles
// assumes the input is quasi-static relative to the destination clock
`timescale 1ns/1ps
module fsw_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    meta_q <= d_i;
    q_o    <= meta_q;
  end
endmodule

//--- fsw_status_latch.sv
// status register and write latch of a serial multi-io flash
// assumes host drives sclk_i only while cs_n_i is low, srst_i is power-up
// Behaviour
// - four-wire mode moves four bits per clock, high nibble first, io3 msb
// - security accesses need address 23-16 zero, 15-12 one to three, 11-9 zero
// - set-write-latch frame of one opcode byte sets the write latch
// - clear-write-latch frame of one opcode byte clears the write latch
// - latch clears at power-up and on completion of writes, programs, erases, reset
// - volatile arm precedes status write, leaves latch, makes write volatile only
// - status reads are served at any time, even while busy
// - 05h returns bits 7-0, 35h bits 15-8; upper io ignored in one-wire mode
// - status word layout fixed from suspended down to busy
// - busy reads one during program, erase or status write cycle
// - with latch clear, programs, erases and status writes without volatile arm are rejected
// - block protect bits shield array, rewritable only without hardware lock; here they gate chip erase only, regions use arr_prot_i
// - chip erase runs only when block protect bits are all clear
// - status protect pair and write-protect pin select status write locking
// - power cycle turns power-supply lock-down into software protection
// - quad enable turns write-protect and hold pins into io2 and io3
// - fail bit set on failed, reset or protected operation, cleared on success
// - security lock bits are one-time settable and lock their register
// - protect invert bit modifies block protect interpretation; here the bit is only stored and read back
// - suspend sets suspended bit, resume or power cycle clears it
// - volatile arm opcode 50h carries no address, dummy or data
`timescale 1ns/1ps
module fsw_status_latch
  import fsw_pkg::*;
#(
  parameter int unsigned TW_NS = 5000000
) (
  input  wire logic            core_clk_i,
  input  wire logic            srst_i,
  input  wire logic            sclk_i,
  input  wire logic            cs_n_i,
  input  wire logic [3:0]      io_i,
  output logic      [3:0]      io_o,
  output logic      [3:0]      io_oe_o,
  input  wire logic            wp_n_i,
  output logic                 quad_en_o,
  output logic                 arr_start_o,
  output fsw_arr_req_type      arr_req_o,
  output logic                 arr_abort_o,
  output logic                 arr_susp_o,
  input  wire logic            arr_prot_i,
  input  wire logic            arr_done_i,
  input  wire logic            arr_fail_i
);
  localparam int unsigned TW_CYC = (TW_NS / CLK_NS < 1) ? 1 : TW_NS / CLK_NS;

  // link domain state
  logic        first_q;
  logic        fr_tog_q;
  logic [7:0]  cnt_q;
  logic        long_q;
  logic [7:0]  sh_q;
  logic [7:0]  opc_q;
  logic [23:0] rx_q;
  logic        four_wire_q;
  logic        rd_en_q;
  logic        rd_hi_q;
  logic [15:0] lsnap_q;
  logic        ack_q;
  logic        snap_l;
  logic [3:0]  step;
  logic [7:0]  cnt_base;
  logic        long_base;
  logic [8:0]  cnt_sum;
  logic [7:0]  opc_nx;
  logic [7:0]  rd_byte;

  // core domain state
  logic            cs_s;
  logic            wp_s;
  logic            cs_d_q;
  logic            seen_q;
  logic            ack_c;
  logic            snap_tog_q;
  logic [15:0]     snap_q;
  fsw_stat_type    st_q;
  fsw_stat_type    nv_q;
  fsw_stat_type    w;
  fsw_state_type   state_q;
  fsw_state_type   state_d;
  logic [31:0]     tw_q;
  logic            varm_q;
  logic            rst_arm_q;
  logic            fe;
  logic            n8;
  logic            n16;
  logic            n24;
  logic            n32;
  logic            n40;
  logic            locked;
  logic            is_arr;
  logic            is_sec;
  logic            is_chip;
  logic            sec_ok;
  logic [1:0]      sec_idx;
  logic            ev_set;
  logic            ev_clr;
  logic            ev_varm;
  logic            ev_srw;
  logic            ev_try;
  logic            ev_bad;
  logic            ev_go;
  logic            ev_susp;
  logic            ev_res;
  logic            ev_rst;
  logic            srw_done;
  logic            arr_end;

  // ---------------- link domain ----------------

  // marks the first clock edge of each frame
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      first_q <= 1'h1;
    end else begin
      first_q <= 1'h0;
    end
  end

  assign step      = four_wire_q ? 4'h4 : 4'h1;
  assign cnt_base  = first_q ? 8'h00 : cnt_q;
  assign long_base = first_q ? 1'h0 : long_q;
  assign cnt_sum   = {1'h0, cnt_base} + {5'h00, step};
  // nibble mode takes io3..io0 per edge, io3 as msb
  assign opc_nx    = four_wire_q ? {sh_q[3:0], io_i} : {sh_q[6:0], io_i[0]};

  // bit counter, opcode and address or data capture
  always_ff @(posedge sclk_i or posedge srst_i) begin
    if (srst_i) begin
      fr_tog_q    <= 1'h0;
      cnt_q       <= 8'h00;
      long_q      <= 1'h0;
      sh_q        <= 8'h00;
      opc_q       <= 8'h00;
      rx_q        <= 24'h000000;
      four_wire_q <= 1'h0;
      rd_en_q     <= 1'h0;
      rd_hi_q     <= 1'h0;
    end else begin
      if (first_q) begin
        fr_tog_q <= ~fr_tog_q;
      end
      cnt_q  <= cnt_sum[7:0];
      long_q <= long_base | cnt_sum[8];
      sh_q   <= opc_nx;
      if (first_q) begin
        rd_en_q <= 1'h0;
      end
      if (!long_base && cnt_sum[7:0] == N_OPC) begin
        opc_q   <= opc_nx;
        // only io0 is read in one-wire mode
        rd_en_q <= (opc_nx == OP_RD_LOW) || (opc_nx == OP_RD_HIGH);
        rd_hi_q <= (opc_nx == OP_RD_HIGH);
        if (opc_nx == OP_QUAD_ON) begin
          four_wire_q <= 1'h1;
        end else if (opc_nx == OP_QUAD_OFF) begin
          four_wire_q <= 1'h0;
        end
      end
      // keep the first three bytes after the opcode
      if (!long_base && cnt_base >= N_OPC && cnt_base < N_ADDR) begin
        rx_q <= four_wire_q ? {rx_q[19:0], io_i} : {rx_q[22:0], io_i[0]};
      end
    end
  end

  // status snapshot taken over from the core, frozen during a read
  always_ff @(posedge sclk_i or posedge srst_i) begin
    if (srst_i) begin
      lsnap_q <= 16'h0000;
      ack_q   <= 1'h0;
    end else if (snap_l != ack_q && !rd_en_q) begin
      lsnap_q <= snap_q;
      ack_q   <= snap_l;
    end
  end

  assign rd_byte = rd_hi_q ? lsnap_q[15:8] : lsnap_q[7:0];

  // read data shifted out on the falling edge
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      io_o    <= 4'h0;
      io_oe_o <= 4'h0;
    end else if (rd_en_q) begin
      if (four_wire_q) begin
        io_oe_o <= 4'hF;
        io_o    <= cnt_q[2] ? rd_byte[3:0] : rd_byte[7:4];
      end else begin
        io_oe_o <= 4'h2;
        io_o    <= {2'h0, rd_byte[~cnt_q[2:0]], 1'h0};
      end
    end else begin
      io_oe_o <= 4'h0;
      io_o    <= 4'h0;
    end
  end

  fsw_sync #(.W(1)) u_sync_snap (
    .clk_i (sclk_i),
    .d_i   (snap_tog_q),
    .q_o   (snap_l)
  );

  // ---------------- core domain ----------------

  fsw_sync #(.W(3)) u_sync_core (
    .clk_i (core_clk_i),
    .d_i   ({cs_n_i, wp_n_i, ack_q}),
    .q_o   ({cs_s, wp_s, ack_c})
  );

  // frame end detect; link registers are still while cs is high
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cs_d_q <= 1'h1;
      seen_q <= 1'h0;
    end else begin
      cs_d_q <= cs_s;
      if (cs_s && !cs_d_q) begin
        seen_q <= fr_tog_q;
      end
    end
  end

  assign fe = cs_s && !cs_d_q && (fr_tog_q != seen_q);

  // status word handed to the link by toggle handshake
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      snap_tog_q <= 1'h0;
      snap_q     <= 16'h0000;
    end else if (ack_c == snap_tog_q) begin
      snap_q     <= st_q;
      snap_tog_q <= ~snap_tog_q;
    end
  end

  // command decode at frame end
  always_comb begin
    n8      = !long_q && cnt_q == N_OPC;
    n16     = !long_q && cnt_q == N_ONE;
    n24     = !long_q && cnt_q == N_TWO;
    n32     = !long_q && cnt_q == N_ADDR;
    n40     = long_q || cnt_q >= N_DATA;
    // hardware lock choices by protect pair and pin
    locked  = (st_q.status_protect == SP_OTP) || (st_q.status_protect == SP_PSU) ||
              (st_q.status_protect == SP_HW && !(wp_s || st_q.quad_en));
    is_sec  = (opc_q == OP_SECURE_ERASE) || (opc_q == OP_SECURE_PROG);
    is_chip = (opc_q == OP_CHIP_ERASE_A) || (opc_q == OP_CHIP_ERASE_B);
    case (opc_q)
      OP_PAGE_PROG, OP_QUAD_PROG: is_arr = n40;
      OP_PAGE_ERASE, OP_SECT_ERASE, OP_HALF_ERASE,
      OP_BLK_ERASE, OP_BUF_PROG: is_arr = n32;
      OP_SECURE_ERASE, OP_SECURE_PROG: is_arr = n32;
      OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: is_arr = n8;
      default: is_arr = 1'h0;
    endcase
    // security register address
    sec_ok  = rx_q[23:16] == SEC_TOP && rx_q[11:9] == SEC_GAP &&
              rx_q[15:12] >= SEC_REG1 && rx_q[15:12] <= SEC_REG3;
    sec_idx = rx_q[13:12] - 2'h1;
  end

  assign ev_set  = fe && n8 && opc_q == OP_SET_LATCH;
  assign ev_clr  = fe && n8 && opc_q == OP_CLR_LATCH;
  assign ev_varm = fe && n8 && opc_q == OP_VOL_ARM;
  // status write needs latch or arm, no lock, exact byte boundary
  assign ev_srw  = fe && state_q == ST_IDLE && !locked && (st_q.write_latch || varm_q) &&
                   ((opc_q == OP_SR_WRITE && (n16 || n24)) ||
                    (opc_q == OP_SR_WRITE_HI && n16));
  // array work needs latch, chip erase needs clear protect
  assign ev_try  = fe && state_q == ST_IDLE && st_q.write_latch && is_arr &&
                   !(is_chip && st_q.block_protect != 5'h00) && !(is_sec && !sec_ok);
  // protected region or locked security register
  assign ev_bad  = ev_try && (arr_prot_i || (is_sec && st_q.sec_lock[sec_idx]));
  assign ev_go   = ev_try && !ev_bad;
  assign ev_susp = fe && n8 && opc_q == OP_SUSPEND && state_q == ST_ARR;
  assign ev_res  = fe && n8 && opc_q == OP_RESUME && st_q.suspended;
  assign ev_rst  = fe && n8 && opc_q == OP_RST && rst_arm_q;
  assign srw_done = state_q == ST_SRW && tw_q == 32'h0000_0000;
  assign arr_end  = state_q == ST_ARR && arr_done_i;

  // next state of the cycle sequencer
  always_comb begin
    case (state_q)
      ST_LOAD: state_d = ST_IDLE;
      ST_IDLE: begin
        if (ev_srw && !varm_q) begin
          state_d = ST_SRW;
        end else if (ev_go) begin
          state_d = ST_ARR;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_SRW: state_d = srw_done ? ST_IDLE : ST_SRW;
      ST_ARR: state_d = (arr_done_i || ev_rst) ? ST_IDLE : ST_ARR;
      default: state_d = ST_LOAD;
    endcase
  end

  // sequencer and status write cycle timer
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_q <= ST_LOAD;
      tw_q    <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      if (state_q == ST_IDLE) begin
        tw_q <= 32'(TW_CYC - 1);
      end else if (state_q == ST_SRW && tw_q != 32'h0000_0000) begin
        tw_q <= tw_q - 32'h0000_0001;
      end
    end
  end

  // new status value from the written bytes
  always_comb begin
    w = st_q;
    if (opc_q == OP_SR_WRITE) begin
      if (n16) begin
        w.protect_invert    = 1'h0;
        w.quad_en           = 1'h0;
        w.status_protect[1] = 1'h0;
      end
      w.status_protect[0] = n16 ? rx_q[7] : rx_q[15];
      w.block_protect     = n16 ? rx_q[6:2] : rx_q[14:10];
    end
    if (n24 || opc_q == OP_SR_WRITE_HI) begin
      w.status_protect[1] = rx_q[0];
      w.quad_en           = rx_q[1];
      w.sec_lock          = st_q.sec_lock | rx_q[5:3];
      w.protect_invert    = rx_q[6];
    end
  end

  // status bits, stored copy and write latch
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st_q      <= STAT_RST;
      nv_q      <= NV_DEFAULT;
      varm_q    <= 1'h0;
      rst_arm_q <= 1'h0;
    end else if (state_q == ST_LOAD) begin
      // working copy loaded from stored bits
      st_q             <= nv_q;
      st_q.write_latch <= 1'h0;
      st_q.busy        <= 1'h0;
      st_q.suspended   <= 1'h0;
      st_q.op_fail     <= 1'h0;
      if (nv_q.status_protect == SP_PSU) begin
        st_q.status_protect <= SP_SOFT;
        nv_q.status_protect <= SP_SOFT;
      end
    end else begin
      st_q.busy <= (state_d == ST_SRW) || (state_d == ST_ARR);
      if (ev_srw) begin
        st_q.protect_invert <= w.protect_invert;
        st_q.sec_lock       <= w.sec_lock;
        st_q.quad_en        <= w.quad_en;
        st_q.status_protect <= w.status_protect;
        st_q.block_protect  <= w.block_protect;
        if (!varm_q) begin
          nv_q <= w;
        end
      end
      if (fe) begin
        rst_arm_q <= n8 && opc_q == OP_RST_ENABLE;
      end
      if (ev_srw || ev_rst) begin
        varm_q <= 1'h0;
      end else if (ev_varm) begin
        varm_q <= 1'h1;
      end
      if (arr_end) begin
        st_q.op_fail <= arr_fail_i;
      end
      if (ev_bad || (ev_rst && state_q == ST_ARR)) begin
        st_q.op_fail <= 1'h1;
      end
      if (ev_res || ev_rst || arr_end) begin
        st_q.suspended <= 1'h0;
      end else if (ev_susp) begin
        st_q.suspended <= 1'h1;
      end
      // clears first so that a same-cycle set wins
      if (ev_clr || srw_done || (ev_srw && varm_q) || arr_end || ev_bad || ev_rst) begin
        st_q.write_latch <= 1'h0;
      end
      if (ev_set) begin
        st_q.write_latch <= 1'h1;
      end
    end
  end

  // start pulse, request and abort towards the array engine
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      arr_start_o <= 1'h0;
      arr_abort_o <= 1'h0;
      arr_req_o   <= REQ_RST;
    end else begin
      arr_start_o <= ev_go;
      arr_abort_o <= ev_rst && state_q == ST_ARR;
      if (ev_go) begin
        arr_req_o.op      <= opc_q;
        arr_req_o.addr    <= rx_q;
        arr_req_o.sec_sel <= is_sec ? rx_q[13:12] : 2'h0;
      end
    end
  end

  assign quad_en_o  = st_q.quad_en;
  assign arr_susp_o = st_q.suspended;

endmodule

//--- fsw_checker.sv
// port assertions for the flash status and write latch block
// assumes core clock domain only; bound onto every fsw_status_latch
`timescale 1ns/1ps
module fsw_checker
  import fsw_pkg::*;
#(
  parameter int unsigned TW_NS = 5000000
) (
  input wire logic            core_clk_i,
  input wire logic            srst_i,
  input wire logic            sclk_i,
  input wire logic            cs_n_i,
  input wire logic [3:0]      io_i,
  input wire logic [3:0]      io_o,
  input wire logic [3:0]      io_oe_o,
  input wire logic            wp_n_i,
  input wire logic            quad_en_o,
  input wire logic            arr_start_o,
  input wire fsw_arr_req_type arr_req_o,
  input wire logic            arr_abort_o,
  input wire logic            arr_susp_o,
  input wire logic            arr_prot_i,
  input wire logic            arr_done_i,
  input wire logic            arr_fail_i
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // link frame closed for two core cycles
  sequence s_link_idle;
    cs_n_i [*2];
  endsequence
  // one-cycle array request
  sequence s_start;
    arr_start_o ##1 !arr_start_o;
  endsequence
  power_up_clear_a: assert property ($fell(srst_i) |-> !arr_start_o && !arr_abort_o
    && !arr_susp_o && !quad_en_o) else $error("outputs not clear after reset");
  start_pulse_a: assert property (arr_start_o |-> s_start)
    else $error("array start longer than one cycle");
  start_after_frame_a: assert property (arr_start_o |-> cs_n_i && $past(cs_n_i, 2))
    else $error("array start inside a frame");
  prot_no_start_a: assert property (arr_prot_i |-> !arr_start_o)
    else $error("start on protected target");
  idle_no_drive_a: assert property (s_link_idle |-> io_oe_o == 4'h0)
    else $error("io driven outside a frame");
  oe_legal_a: assert property (io_oe_o inside {4'h0, 4'h2, 4'hF})
    else $error("illegal io enable pattern");
  susp_at_idle_a: assert property ($changed(arr_susp_o) |-> cs_n_i && $past(cs_n_i))
    else $error("suspended bit moved inside a frame");
  abort_pulse_a: assert property (arr_abort_o |-> cs_n_i ##1 !arr_abort_o)
    else $error("abort not a single idle pulse");
  req_hold_a: assert property ($changed(arr_req_o) |-> arr_start_o || $past(arr_start_o))
    else $error("array request changed without start");
  sec_addr_a: assert property (arr_start_o && arr_req_o.sec_sel != 2'h0 |->
    arr_req_o.addr[23:16] == SEC_TOP && arr_req_o.addr[11:9] == SEC_GAP &&
    arr_req_o.addr[15:12] == {2'h0, arr_req_o.sec_sel}) else $error("bad security address");
  start_seen_c: cover property (s_link_idle ##1 s_start);
endmodule

bind fsw_status_latch fsw_checker #(.TW_NS(TW_NS)) u_chk (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
  .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o), .wp_n_i(wp_n_i),
  .quad_en_o(quad_en_o), .arr_start_o(arr_start_o), .arr_req_o(arr_req_o),
  .arr_abort_o(arr_abort_o), .arr_susp_o(arr_susp_o), .arr_prot_i(arr_prot_i),
  .arr_done_i(arr_done_i), .arr_fail_i(arr_fail_i));

//--- fsw_host.sv
// host controller model: frames commands and reads status bytes
// assumes the bench resolves io lines from the device's enables
`timescale 1ns/1ps
module fsw_host (
  output logic            sclk_o,
  output logic            cs_n_o,
  output logic [3:0]      io_o,
  input  wire logic [3:0] sio_i,
  output logic [7:0]      rd_o,
  output logic            rd_tick_o
);
  localparam int HALF = 40;
  logic qm;
  // link idles with clock still low and select high
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h5;
    rd_o = 8'h00;
    rd_tick_o = 1'b0;
    qm = 1'b0;
  end
  // one byte msb first; four-wire sends high nibble first, io3 msb
  task automatic shift(input logic [7:0] b);
    for (int i = qm ? 4 : 7; i >= 0; i -= qm ? 4 : 1) begin
      io_o = qm ? b[i+:4] : {~io_o[3:1], b[i]};
      #HALF sclk_o = 1'b1;
      #HALF sclk_o = 1'b0;
    end
  endtask
  // select high, clock stands still, released lines flip
  task automatic stop;
    #HALF cs_n_o = 1'b1;
    io_o = ~io_o;
    #700;
  endtask
  // opcode then nb bytes, no dummy cycles
  task automatic cmd(input logic [7:0] op, input int nb, input logic [31:0] d);
    cs_n_o = 1'b0;
    #HALF;
    shift(op);
    for (int k = nb - 1; k >= 0; k--)
      shift(d[8*k+:8]);
    stop;
  endtask
  // two read frames, the first refreshes the status snapshot
  task automatic rd(input logic [7:0] op);
    repeat (2) begin
      cs_n_o = 1'b0;
      #HALF;
      shift(op);
      repeat (qm ? 2 : 8) begin
        io_o = ~io_o;
        #HALF sclk_o = 1'b1;
        rd_o = qm ? {rd_o[3:0], sio_i} : {rd_o[6:0], sio_i[1]};
        #HALF sclk_o = 1'b0;
      end
      stop;
    end
    rd_tick_o = 1'b1;
    #1 rd_tick_o = 1'b0;
  endtask
endmodule

//--- testbench.sv
// self-checking bench for the status and write latch block
// assumes fsw_host drives the link; array engine side is driven here
`timescale 1ns/1ps
module testbench;
  import fsw_pkg::*;
  logic            core_clk_i = 1'b0;
  logic            srst_i     = 1'b1;
  logic            wp_n_i     = 1'b1;
  logic            arr_prot_i = 1'b0;
  logic            arr_done_i = 1'b0;
  logic            arr_fail_i = 1'b0;
  logic [3:0]      io_i, io_o, io_oe_o, host_io;
  logic            sclk, cs_n, quad_en_o, arr_start_o, arr_abort_o, arr_susp_o;
  fsw_arr_req_type arr_req_o;
  logic [7:0]      rd_byte, exp_q[$];
  logic            rd_tick;
  logic [31:0]     st_q[$];
  logic [23:0]     amask = '1;
  int              fail_count = 0, tests_run = 0, aborts = 0, seed = 37278;
  logic [7:0]      ops[7] = '{8'h02, 8'h32, 8'h81, 8'h20, 8'h52, 8'hD8, 8'h9D};

  always #50 core_clk_i = ~core_clk_i;
  // wire level from the device's enables, host value elsewhere
  assign io_i = (io_oe_o & io_o) | (~io_oe_o & host_io);

  fsw_status_latch #(.TW_NS(20000)) u_dut (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o),
    .wp_n_i(wp_n_i), .quad_en_o(quad_en_o), .arr_start_o(arr_start_o),
    .arr_req_o(arr_req_o), .arr_abort_o(arr_abort_o), .arr_susp_o(arr_susp_o),
    .arr_prot_i(arr_prot_i), .arr_done_i(arr_done_i), .arr_fail_i(arr_fail_i));
  fsw_host u_host (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(host_io), .sio_i(io_i),
    .rd_o(rd_byte), .rd_tick_o(rd_tick));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // note the byte, then read it over the link
  task automatic rd(input logic [7:0] op, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.rd(op);
  endtask
  task automatic done(input logic f);
    @(posedge core_clk_i);
    #1 arr_done_i = 1'b1;
    arr_fail_i = f;
    @(posedge core_clk_i);
    #1 arr_done_i = 1'b0;
    arr_fail_i = 1'b0;
  endtask
  // latch first, then an array command expected to start
  task automatic arr(input logic [7:0] op, input int nb, input logic [23:0] a);
    u_host.cmd(OP_SET_LATCH, 0, 32'h0);
    st_q.push_back({op, a & amask});
    u_host.cmd(op, nb, nb == 4 ? {a, 8'h5A} : {8'h00, a});
  endtask
  task automatic vol(input logic [7:0] d);
    u_host.cmd(OP_VOL_ARM, 0, 32'h0);
    u_host.cmd(OP_SR_WRITE, 1, {24'h0, d});
  endtask

  // results as they appear, against the oldest note
  always @(posedge rd_tick)
    chk("status byte", {24'h0, exp_q.size() ? exp_q.pop_front() : 8'hXX}, {24'h0, rd_byte});
  always @(posedge core_clk_i) begin
    if (arr_start_o === 1'b1)
      chk("array request", st_q.size() ? st_q.pop_front() : 'X,
        {arr_req_o.op, arr_req_o.addr & amask});
    if (arr_abort_o === 1'b1)
      aborts++;
  end
  initial begin
    repeat (90000) @(posedge core_clk_i);
    fail_count++;
    end_sim;
  end

  initial begin
    repeat (12) @(posedge core_clk_i);
    #1 srst_i = 1'b0;
    repeat (3) @(posedge core_clk_i);
    rd(OP_RD_LOW, 8'h00);
    rd(OP_RD_HIGH, 8'h00);
    u_host.cmd(OP_SET_LATCH, 0, 32'h0);
    rd(OP_RD_LOW, 8'h02);
    u_host.cmd(OP_CLR_LATCH, 0, 32'h0);
    rd(OP_RD_LOW, 8'h00);
    u_host.cmd(OP_PAGE_PROG, 4, 32'h0);
    rd(OP_RD_LOW, 8'h00);
    $display("test latch done");
    foreach (ops[i]) begin
      arr(ops[i], ops[i] == OP_PAGE_PROG || ops[i] == OP_QUAD_PROG ? 4 : 3, 24'($random(seed)));
      rd(OP_RD_LOW, 8'h03);
      done(i == 1);
      rd(OP_RD_HIGH, i == 1 ? 8'h04 : 8'h00);
      rd(OP_RD_LOW, 8'h00);
    end
    arr(OP_SECURE_ERASE, 3, 24'h002000);
    done(1'b0);
    $display("test array ops done");
    @(posedge core_clk_i);
    #1 arr_prot_i = 1'b1;
    u_host.cmd(OP_SET_LATCH, 0, 32'h0);
    u_host.cmd(OP_SECT_ERASE, 3, 32'h000100);
    rd(OP_RD_HIGH, 8'h04);
    rd(OP_RD_LOW, 8'h00);
    @(posedge core_clk_i);
    #1 arr_prot_i = 1'b0;
    vol(8'h1C);
    rd(OP_RD_LOW, 8'h1C);
    u_host.cmd(OP_SET_LATCH, 0, 32'h0);
    u_host.cmd(OP_CHIP_ERASE_A, 0, 32'h0);
    rd(OP_RD_LOW, 8'h1E);
    vol(8'h00);
    amask = '0;
    arr(OP_CHIP_ERASE_B, 0, 24'h0);
    done(1'b0);
    amask = '1;
    $display("test protection done");
    vol(8'h80);
    @(posedge core_clk_i);
    #1 wp_n_i = 1'b0;
    vol(8'h9C);
    rd(OP_RD_LOW, 8'h80);
    @(posedge core_clk_i);
    #1 wp_n_i = 1'b1;
    vol(8'h00);
    rd(OP_RD_LOW, 8'h00);
    u_host.cmd(OP_SET_LATCH, 0, 32'h0);
    u_host.cmd(OP_SR_WRITE, 2, 32'h0002);
    rd(OP_RD_LOW, 8'h03);
    #25000;
    rd(OP_RD_LOW, 8'h00);
    chk("quad enable", 32'h1, {31'h0, quad_en_o});
    u_host.cmd(OP_QUAD_ON, 0, 32'h0);
    u_host.qm = 1'b1;
    rd(OP_RD_HIGH, 8'h02);
    u_host.cmd(OP_QUAD_OFF, 0, 32'h0);
    u_host.qm = 1'b0;
    $display("test status write done");
    arr(OP_SECT_ERASE, 3, 24'($random(seed)));
    u_host.cmd(OP_SUSPEND, 0, 32'h0);
    chk("suspend level", 32'h1, {31'h0, arr_susp_o});
    rd(OP_RD_HIGH, 8'h82);
    u_host.cmd(OP_RESUME, 0, 32'h0);
    chk("suspend level", 32'h0, {31'h0, arr_susp_o});
    done(1'b0);
    arr(OP_BLK_ERASE, 3, 24'($random(seed)));
    u_host.cmd(OP_RST_ENABLE, 0, 32'h0);
    u_host.cmd(OP_RST, 0, 32'h0);
    chk("abort count", 32'h1, 32'(aborts));
    rd(OP_RD_LOW, 8'h00);
    chk("pending requests", 32'h0, 32'(st_q.size()));
    $display("test suspend and reset done");
    end_sim;
  end
endmodule
